// ### hdl/conv_pkg.sv
// Purpose: shared constants for the sar converter sequencer
// Assumes: 8-bit special function register port, 100 MHz system clock
// Notes: register offsets are special function addresses
package conv_pkg;
   localparam logic [7:0] CONV_CONTROL_ADDR = 8'h93;
   localparam logic [7:0] CONV_TIMING_ADDR = 8'h94;
   localparam logic [7:0] PIN_CONFIG_ADDR = 8'h95;
   localparam logic [7:0] RESULT_LOW_ADDR = 8'h96;
   localparam logic [7:0] RESULT_HIGH_ADDR = 8'h97;
   localparam logic [7:0] REG_RESET = 8'h00;
   // control bit positions
   localparam int CTL_ON_BIT = 7;
   localparam int CTL_FLAG_BIT = 6;
   localparam int CTL_CMP_BIT = 5;
   localparam int CTL_SEL_HI = 3;
   localparam int CTL_SEL_LO = 1;
   localparam int CTL_START_BIT = 0;
   // timing register fields
   localparam int TIM_DIV_HI = 7;
   localparam int TIM_DIV_LO = 5;
   localparam int TIM_LEN_HI = 3;
   localparam int TIM_LEN_LO = 0;
   // control register bit 4 is unused and reads zero
   localparam logic [7:0] CTL_WMASK = 8'hef;
   localparam logic [7:0] TIM_WMASK = 8'hef;
   localparam logic [7:0] LOW_WMASK = 8'h03;
   // sample window clamps, in converter clocks
   localparam logic [4:0] SAMPLE_MIN = 5'h02;
   localparam logic [4:0] SAMPLE_MAX = 5'h0f;
   // conversion phase length in converter clocks
   localparam logic [4:0] CONV_CLOCKS = 5'h0c;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b11,
      ST_DONE = 2'b10
   } conv_state_t;
endpackage : conv_pkg

// ### hdl/sar_adc_sequencer_compare.sv
// Purpose: control for an eight-input 10-bit successive-approximation converter
// Assumes: single clock i_clk, synchronous reset, core result presented on i_core_data
// Notes: core data is sampled through two flops before use
`timescale 1ns/100ps
module sar_adc_sequencer_compare #(
   parameter int DATA_W = 10,
   parameter int NUM_INPUTS = 8
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // special function register port
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   // processor power state and interrupt enable
   input wire logic i_power_down,
   input wire logic i_conv_irq_enable,
   output logic o_conv_irq,
   // analog core
   input wire logic [DATA_W-1:0] i_core_data,
   output logic [NUM_INPUTS-1:0] o_input_route,
   output logic [NUM_INPUTS-1:0] o_analog_pin_bits,
   output logic o_core_sample,
   output logic o_core_enable,
   output logic o_conv_clk
);
   logic [7:0] ctl_q;
   logic [7:0] tim_q;
   logic [7:0] pin_q;
   logic [7:0] res_lo_q;
   logic [7:0] res_hi_q;
   conv_pkg::conv_state_t state_q;
   logic [4:0] div_cnt_q;
   logic tick;
   logic [4:0] div_len;
   logic [4:0] phase_cnt_q;
   logic [4:0] sample_len;
   logic [DATA_W-1:0] core_s1_q;
   logic [DATA_W-1:0] core_s2_q;
   logic active;
   logic done_evt;
   logic hit;
   logic wr_ctl;
   logic [DATA_W-1:0] stored;
   logic [4:0] div_half;
   logic [7:0] rdata_d;
   logic wr_tim;
   logic wr_pin;
   logic wr_lo;
   logic wr_hi;
   logic load_result;
   logic set_flag;

   // power-down halts the sequencer, divider and core; idle mode has no effect here
   assign active = ctl_q[conv_pkg::CTL_ON_BIT] & ~i_power_down;
   assign wr_ctl = i_sfr_wr && (i_sfr_addr == conv_pkg::CONV_CONTROL_ADDR);
   assign wr_tim = i_sfr_wr && (i_sfr_addr == conv_pkg::CONV_TIMING_ADDR);
   assign wr_pin = i_sfr_wr && (i_sfr_addr == conv_pkg::PIN_CONFIG_ADDR);
   assign wr_lo = i_sfr_wr && (i_sfr_addr == conv_pkg::RESULT_LOW_ADDR);
   assign wr_hi = i_sfr_wr && (i_sfr_addr == conv_pkg::RESULT_HIGH_ADDR);
   assign stored = {res_hi_q, res_lo_q[1:0]};

   // core data comes from another timing domain, so it is double-flopped
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         core_s1_q <= '0;
         core_s2_q <= '0;
      end else begin
         core_s1_q <= i_core_data;
         core_s2_q <= core_s1_q;
      end
   end

   // divider length, full period in system clocks
   always_comb begin
      case (tim_q[conv_pkg::TIM_DIV_HI:conv_pkg::TIM_DIV_LO])
         3'h0: div_len = 5'h02;
         3'h1: div_len = 5'h04;
         3'h2: div_len = 5'h06;
         3'h3: div_len = 5'h08;
         3'h4: div_len = 5'h0c;
         3'h5: div_len = 5'h10;
         3'h6: div_len = 5'h18;
         default: div_len = 5'h00;
      endcase
   end

   // code 111 leaves div_len at zero, so its half point is set apart
   always_comb begin
      if (div_len == 5'h00) begin
         div_half = 5'h10;
      end else begin
         div_half = {1'b0, div_len[4:1]};
      end
   end

   // 5-bit counter wraps at 32 naturally for code 111
   assign tick = active && (div_cnt_q == div_len - 5'h01);

   // divider restarts in idle and done, so every window opens on a whole period
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         div_cnt_q <= '0;
         o_conv_clk <= 1'b0;
      end else if (!active || state_q == conv_pkg::ST_IDLE
         || state_q == conv_pkg::ST_DONE) begin
         div_cnt_q <= '0;
         o_conv_clk <= 1'b0;
      end else begin
         div_cnt_q <= tick ? 5'h00 : div_cnt_q + 5'h01;
         o_conv_clk <= (div_cnt_q >= div_half);
      end
   end

   // sample length with clamp
   always_comb begin
      sample_len = {1'b0, tim_q[conv_pkg::TIM_LEN_HI:conv_pkg::TIM_LEN_LO]} + 5'h01;
      if (sample_len < conv_pkg::SAMPLE_MIN) begin
         sample_len = conv_pkg::SAMPLE_MIN;
      end else if (sample_len > conv_pkg::SAMPLE_MAX) begin
         sample_len = conv_pkg::SAMPLE_MAX;
      end
   end

   assign done_evt = (state_q == conv_pkg::ST_DONE);
   assign hit = core_s2_q > stored;
   // compare mode keeps the threshold, so only plain conversions load a result
   assign load_result = done_evt && !ctl_q[conv_pkg::CTL_CMP_BIT];
   assign set_flag = done_evt && (!ctl_q[conv_pkg::CTL_CMP_BIT] || hit);

   // sequencer
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= conv_pkg::ST_IDLE;
         phase_cnt_q <= '0;
      end else if (!active || !ctl_q[conv_pkg::CTL_START_BIT]) begin
         // a cleared start bit aborts any conversion in flight
         state_q <= conv_pkg::ST_IDLE;
         phase_cnt_q <= '0;
      end else begin
         case (state_q)
            conv_pkg::ST_IDLE: begin
               state_q <= conv_pkg::ST_SAMPLE;
               phase_cnt_q <= '0;
            end
            conv_pkg::ST_SAMPLE: begin
               if (tick) begin
                  if (phase_cnt_q == sample_len - 5'h01) begin
                     state_q <= conv_pkg::ST_CONVERT;
                     phase_cnt_q <= '0;
                  end else begin
                     phase_cnt_q <= phase_cnt_q + 5'h01;
                  end
               end
            end
            conv_pkg::ST_CONVERT: begin
               if (tick) begin
                  if (phase_cnt_q == conv_pkg::CONV_CLOCKS - 5'h01) begin
                     state_q <= conv_pkg::ST_DONE;
                     phase_cnt_q <= '0;
                  end else begin
                     phase_cnt_q <= phase_cnt_q + 5'h01;
                  end
               end
            end
            conv_pkg::ST_DONE: begin
               if (ctl_q[conv_pkg::CTL_CMP_BIT]) begin
                  // compare mode loops straight into the next sample
                  state_q <= conv_pkg::ST_SAMPLE;
               end else begin
                  // a single conversion rests while the start bit drops
                  state_q <= conv_pkg::ST_IDLE;
               end
               phase_cnt_q <= '0;
            end
            default: begin
               state_q <= conv_pkg::ST_IDLE;
               phase_cnt_q <= '0;
            end
         endcase
      end
   end

   // control register; hardware set of the flag wins over a software clear
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctl_q <= conv_pkg::REG_RESET;
      end else begin
         if (wr_ctl) begin
            ctl_q <= i_sfr_wdata & conv_pkg::CTL_WMASK;
            // start only accepted while enabled
            ctl_q[conv_pkg::CTL_START_BIT] <= i_sfr_wdata[conv_pkg::CTL_START_BIT]
               & i_sfr_wdata[conv_pkg::CTL_ON_BIT];
            // software may only clear the flag
            ctl_q[conv_pkg::CTL_FLAG_BIT] <= ctl_q[conv_pkg::CTL_FLAG_BIT]
               & i_sfr_wdata[conv_pkg::CTL_FLAG_BIT];
         end else if (load_result) begin
            ctl_q[conv_pkg::CTL_START_BIT] <= 1'b0;
         end
         if (set_flag) begin
            ctl_q[conv_pkg::CTL_FLAG_BIT] <= 1'b1;
         end
      end
   end

   // timing register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tim_q <= conv_pkg::REG_RESET;
      end else if (wr_tim) begin
         tim_q <= i_sfr_wdata & conv_pkg::TIM_WMASK;
      end
   end

   // pin configuration register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pin_q <= conv_pkg::REG_RESET;
      end else if (wr_pin) begin
         pin_q <= i_sfr_wdata;
      end
   end

   // result high byte; a finished conversion beats a software write
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         res_hi_q <= conv_pkg::REG_RESET;
      end else if (load_result) begin
         res_hi_q <= core_s2_q[DATA_W-1:2];
      end else if (wr_hi) begin
         res_hi_q <= i_sfr_wdata;
      end
   end

   // result low bits
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         res_lo_q <= conv_pkg::REG_RESET;
      end else if (load_result) begin
         res_lo_q <= {6'h00, core_s2_q[1:0]};
      end else if (wr_lo) begin
         res_lo_q <= i_sfr_wdata & conv_pkg::LOW_WMASK;
      end
   end

   // routing: one-hot decode of select field, one input only
   genvar gi;
   generate
      for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_route
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               // select field resets to zero, so input zero is routed from the start
               o_input_route[gi] <= (gi == 0) ? 1'b1 : 1'b0;
            end else begin
               o_input_route[gi] <= (ctl_q[conv_pkg::CTL_SEL_HI:conv_pkg::CTL_SEL_LO]
                  == 3'(gi));
            end
         end
      end
   endgenerate

   // read multiplexer; unmapped addresses read zero
   always_comb begin
      case (i_sfr_addr)
         conv_pkg::CONV_CONTROL_ADDR: rdata_d = ctl_q;
         conv_pkg::CONV_TIMING_ADDR: rdata_d = tim_q;
         conv_pkg::PIN_CONFIG_ADDR: rdata_d = pin_q;
         conv_pkg::RESULT_LOW_ADDR: rdata_d = res_lo_q;
         conv_pkg::RESULT_HIGH_ADDR: rdata_d = res_hi_q;
         default: rdata_d = 8'h00;
      endcase
   end

   // read data holds between reads
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_sfr_rdata <= 8'h00;
      end else if (i_sfr_rd) begin
         o_sfr_rdata <= rdata_d;
      end
   end

   // interrupt request follows the flag while enabled
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_conv_irq <= 1'b0;
      end else begin
         o_conv_irq <= ctl_q[conv_pkg::CTL_FLAG_BIT] & i_conv_irq_enable;
      end
   end

   // pin configuration to the port muxes
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_analog_pin_bits <= '0;
      end else begin
         o_analog_pin_bits <= pin_q;
      end
   end

   // sample switch closes for the whole window
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_core_sample <= 1'b0;
      end else begin
         o_core_sample <= (state_q == conv_pkg::ST_SAMPLE);
      end
   end

   // core power follows the enable bit and power-down
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_core_enable <= 1'b0;
      end else begin
         o_core_enable <= active;
      end
   end
endmodule : sar_adc_sequencer_compare

// ### tb/analog_core_model.sv
// Purpose: behavioural analog core returning a level per routed input
// Assumes: route is one-hot and the level holds steady during a conversion
// Notes: while disabled the data toggles every cycle so a stale result cannot pass
`timescale 1ns/100ps
module analog_core_model (
   // clock
   input wire logic i_clk,
   // converter side
   input wire logic [7:0] i_route,
   input wire logic i_enable,
   input wire logic [9:0] i_level,
   output logic [9:0] o_data = 10'h155
);
   logic [9:0] idx;
   always_comb begin
      idx = 10'h000;
      for (int k = 0; k < 8; k++) if (i_route[k]) idx = 10'(k);
   end
   always @(posedge i_clk) begin
      o_data <= i_enable ? i_level + idx : ~o_data;
   end
endmodule : analog_core_model

// ### tb/sar_adc_sequencer_compare_assertions.sv
// Purpose: port-level assertions for the converter sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: last write is captured so pin relations allow one cycle of slack
`timescale 1ns/100ps
module sar_adc_sequencer_compare_checker (
   // clock, reset and register port
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic [7:0] o_sfr_rdata,
   // power, interrupt and converter side
   input wire logic i_power_down,
   input wire logic i_conv_irq_enable,
   input wire logic o_conv_irq,
   input wire logic o_core_sample,
   input wire logic o_core_enable,
   input wire logic o_conv_clk,
   input wire logic [7:0] o_input_route,
   input wire logic [7:0] o_analog_pin_bits
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic [7:0] wa_q;
   logic [7:0] wd_q;
   // address of last cycle's write, zero when there was none
   always_ff @(posedge i_clk) begin
      wa_q <= i_sfr_wr ? i_sfr_addr : 8'h00;
      wd_q <= i_sfr_wdata;
   end
   onehot_route_a: assert property ($onehot(o_input_route))
      else $error("input route not one-hot");
   route_follows_a: assert property (wa_q == 8'h93 |-> ##[0:1]
      o_input_route == 8'(1 << wd_q[3:1])) else $error("route differs from select field");
   pins_follow_a: assert property (wa_q == 8'h95 |-> ##[0:1]
      o_analog_pin_bits == wd_q) else $error("pin bits differ from written value");
   irq_gated_a: assert property (o_conv_irq |-> $past(i_conv_irq_enable))
      else $error("interrupt raised while disabled");
   powerdown_off_a: assert property (i_power_down |=> !o_core_enable)
      else $error("core enabled in power-down");
   disable_off_a: assert property (wa_q == 8'h93 && !wd_q[7] |-> ##[0:1]
      !o_core_enable) else $error("core enabled after disable write");
   low_bits_a: assert property (i_sfr_rd && i_sfr_addr == 8'h96 |=>
      o_sfr_rdata[7:2] == 6'h00) else $error("low result upper bits not zero");
   sample_min_a: assert property ($rose(o_core_sample) |-> o_core_sample [*4])
      else $error("sample window shorter than two converter clocks");
   conv_clk_idle_a: assert property (!o_core_enable |-> !o_conv_clk)
      else $error("converter clock running while disabled");
   cover property ($rose(o_conv_irq));
   cover property ($rose(o_core_sample));
   cover property (wa_q == 8'h93 && wd_q[0]);
endmodule : sar_adc_sequencer_compare_checker
bind sar_adc_sequencer_compare sar_adc_sequencer_compare_checker u_checker (.i_clk, .i_rst,
   .i_sfr_wr, .i_sfr_rd, .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata, .i_power_down,
   .i_conv_irq_enable, .o_conv_irq, .o_core_sample, .o_core_enable, .o_conv_clk,
   .o_input_route, .o_analog_pin_bits);

// ### tb/sar_adc_sequencer_compare_bench.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: core model returns level plus the routed input index
// Notes: random levels and sample fields from a fixed seed, corners by hand
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module sar_adc_sequencer_compare_bench;
   logic i_clk = 0, i_rst = 1, i_sfr_wr = 0, i_sfr_rd = 0, i_power_down = 0;
   logic i_conv_irq_enable = 1, o_conv_irq, o_core_sample, o_core_enable;
   logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, o_input_route, o_analog_pin_bits;
   logic [7:0] r;
   logic [9:0] i_core_data, level = 10'h000;
   logic conv_clk;
   int num_errors = 0, check_count = 0, n, rises = 0;
   always #5 i_clk = ~i_clk;
   always @(posedge conv_clk) rises++;
   sar_adc_sequencer_compare u_dut (.i_clk, .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
      .i_sfr_wdata, .o_sfr_rdata, .i_power_down, .i_conv_irq_enable, .o_conv_irq,
      .i_core_data, .o_input_route, .o_analog_pin_bits, .o_core_sample, .o_core_enable,
      .o_conv_clk(conv_clk));
   analog_core_model u_core (.i_clk(i_clk), .i_route(o_input_route), .i_enable(o_core_enable),
      .i_level(level), .o_data(i_core_data));
   function automatic int div_of(input int c);
      int t[8] = '{2, 4, 6, 8, 12, 16, 24, 32};
      return t[c];
   endfunction : div_of
   function automatic int samp(input logic [3:0] t);
      return (t == 4'h0) ? 2 : (t == 4'hf) ? 15 : int'(t) + 1;
   endfunction : samp
   task automatic wr(input logic [7:0] a, d);
      @(negedge i_clk);
      i_sfr_addr = a;
      i_sfr_wdata = d;
      i_sfr_wr = 1;
      @(negedge i_clk);
      i_sfr_wr = 0;
   endtask : wr
   task automatic chk_rd(input logic [7:0] a, e);
      @(negedge i_clk);
      i_sfr_addr = a;
      i_sfr_rd = 1;
      @(negedge i_clk);
      i_sfr_rd = 0;
      @(negedge i_clk);
      `CHK("sfr read", e, o_sfr_rdata)
   endtask : chk_rd
   task automatic wait_irq(output int c);
      c = 0;
      while (o_conv_irq !== 1'b1 && c < 2000) begin
         @(negedge i_clk);
         c++;
      end
   endtask : wait_irq
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   initial begin
      #200000;
      num_errors++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(3714));
      repeat (12) @(negedge i_clk);
      i_rst = 0;
      for (int a = 'h93; a < 'h99; a++) chk_rd(8'(a), 8'h00);
      wr(8'h94, 8'hff);
      chk_rd(8'h94, 8'hef);
      wr(8'h96, 8'hff);
      chk_rd(8'h96, 8'h03);
      r = 8'($urandom);
      wr(8'h95, r);
      chk_rd(8'h95, r);
      // each select code paired with the divider code of the same value, clamps at both ends
      for (int s = 0; s < 8; s++) begin
         logic [3:0] ts;
         int base, r0;
         ts = (s == 0) ? 4'h0 : (s == 7) ? 4'hf : 4'($urandom);
         level = 10'($urandom % 1000);
         base = div_of(s) * (samp(ts) + 12);
         wr(8'h94, {3'(s), 1'b0, ts});
         r0 = rises;
         wr(8'h93, {4'h8, 3'(s), 1'b1});
         wait_irq(n);
         `CHK("latency", 1'b1, n >= base && n <= base + div_of(s) + 5)
         `CHK("conv clock periods", samp(ts) + 12, rises - r0)
         chk_rd(8'h97, 8'((level + s) >> 2));
         chk_rd(8'h96, {6'h00, 2'(level + s)});
         chk_rd(8'h93, {4'hc, 3'(s), 1'b0});
         i_conv_irq_enable = 0;
         repeat (2) @(negedge i_clk);
         `CHK("irq masked", 1'b0, o_conv_irq)
         i_conv_irq_enable = 1;
         wr(8'h93, 8'h80);
         chk_rd(8'h93, 8'h80);
      end
      wr(8'h93, 8'h01);
      chk_rd(8'h93, 8'h00);
      `CHK("no sample", 1'b0, o_core_sample)
      wr(8'h94, 8'h00);
      wr(8'h93, 8'h81);
      repeat (10) @(negedge i_clk);
      wr(8'h93, 8'h80);
      repeat (40) @(negedge i_clk);
      `CHK("aborted irq", 1'b0, o_conv_irq)
      // threshold equal to input must not hit: strictly larger only
      wr(8'h97, 8'h80);
      wr(8'h96, 8'h00);
      level = 10'd512;
      wr(8'h93, 8'ha1);
      repeat (150) @(negedge i_clk);
      `CHK("equal no hit", 1'b0, o_conv_irq)
      chk_rd(8'h93, 8'ha1);
      level = 10'd900;
      wait_irq(n);
      `CHK("hit", 1'b1, o_conv_irq)
      chk_rd(8'h97, 8'h80);
      wr(8'h93, 8'ha1);
      repeat (2) @(negedge i_clk);
      wait_irq(n);
      `CHK("hit again", 1'b1, o_conv_irq)
      wr(8'h93, 8'h81);
      repeat (100) @(negedge i_clk);
      chk_rd(8'h93, 8'hc0);
      i_power_down = 1;
      wr(8'h93, 8'h81);
      repeat (60) @(negedge i_clk);
      `CHK("halted irq", 1'b0, o_conv_irq)
      `CHK("core off", 1'b0, o_core_enable)
      wr(8'h93, 8'h00);
      tally_and_finish();
   end
endmodule : sar_adc_sequencer_compare_bench
